// file: rtl/adc_trigger_control.sv
// Purpose: Converter control with timer-driven delayed start requests
// Assumes: Timer events are one-cycle pulses synchronous to pclk
// Notes:   Converter core is a counter; sample data arrives on a port
// Contract
// - No request B from ch3 skip when link bit clear
// - No request B from ch4 skip when link bit clear
// - Trigger select picks source; 0003 picks request A
// - Bit 15 end flag; bit 14 enables interrupt
// - Bit 12 switches on input amplifier
// - Bit 11 enables external and timer triggers
// - End-flag control bit ignored in single mode
// - Time select 0 gives 50-state conversion
// - Clock field 10 selects clock divided by 2
// - Mode field 00 selects single mode
// - Continuous-scan bit 0 gives single-cycle scan
// - Channel field 000 selects input channel 0
// - Compare A request only when enable set
// - Timer issues delayed requests A, B as triggers
// - Up-count enable allows request A counting up
// - Request A follows ch3 skip when linked
`timescale 1ns/1ns
module adc_trigger_control
	import adc_trigger_pkg::*;
(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire adc_trigger_pkg::apb_req_t apb,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire adc_trigger_pkg::timer_evt_t tmr,
	input  wire logic [9:0]              adc_sample_data,
	output logic                         delayed_start_request_a,
	output logic                         delayed_start_request_b,
	output logic                         compare_a_conv_request,
	output logic [2:0]                   analog_channel,
	output logic                         input_amp_on,
	output logic                         conv_busy,
	output logic                         conversion_end_interrupt,
	output logic                         irq
);
	import adc_trigger_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		conv_state_t cs;
		logic [15:0] trg_sel;
		logic        end_flag;
		logic        end_irq_en;
		logic        amp_on;
		logic        hw_trg_en;
		logic        end_ctrl;
		logic        time_sel;
		logic [1:0]  cksl;
		logic [1:0]  adm;
		logic        cont_scan;
		logic [2:0]  ch;
		logic [15:0] req_ctrl;
		logic        cmp_req_en;
		logic [1:0]  ists;
		logic [1:0]  imask;
		logic [9:0]  result;
		logic [9:0]  cnt;
		logic        req_a;
		logic        req_b;
		logic        cmp_req;
		logic [31:0] rdata;
		logic        err;
	} st_t;

	st_t state_reg;
	st_t state_next;

	// Cycles per conversion, minus one, from states and clock divider
	function automatic logic [9:0] conv_cycles(input logic long_sel,
		input logic [1:0] cksl);
		logic [6:0] states;
		logic [1:0] sh;
		states = long_sel ? CONV_STATES_LONG : CONV_STATES_SHORT;
		sh = 2'd3 - cksl;
		return 10'(({3'b000, states} << sh) - 10'd1);
	endfunction

	function automatic logic link_ok(input logic l3, input logic l4,
		input logic p3, input logic p4);
		return !(l3 || l4) || (l3 && p3) || (l4 && p4);
	endfunction

	// ------------------------------------------------------------------
	// Combinational
	// ------------------------------------------------------------------
	logic        wr;
	logic        setup;
	logic        hit;
	logic        ok_a;
	logic        ok_b;
	logic        src_pulse;
	logic        trig;
	logic        accept;
	logic        done;
	logic [15:0] csr_rd;

	always_comb begin
		st_t n;
		n = state_reg;
		setup = apb.psel && !apb.penable;
		wr = apb.psel && apb.penable && apb.pwrite;
		hit = 1'b1;
		unique case (apb.paddr)
			OFS_TRIGGER_SELECT, OFS_CONTROL_STATUS, OFS_TIMER_REQ_CTRL,
			OFS_CMP_REQ_EN, OFS_IRQ_STATUS, OFS_IRQ_MASK,
			OFS_RESULT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
		csr_rd = {state_reg.end_flag, state_reg.end_irq_en, 1'b0,
			state_reg.amp_on, state_reg.hw_trg_en, 1'b0,
			state_reg.end_ctrl, state_reg.time_sel, state_reg.cksl,
			state_reg.adm, state_reg.cont_scan, state_reg.ch};

		// Delayed requests gated by count direction and skip linkage
		ok_a = (tmr.ch4_counting_up ? state_reg.req_ctrl[TR_UP_A]
			: state_reg.req_ctrl[TR_DOWN_A])
			&& link_ok(state_reg.req_ctrl[TR_A_CH3_LINK],
			state_reg.req_ctrl[TR_A_CH4_LINK],
			tmr.ch3_skip_point, tmr.ch4_ovf_skip_point);
		ok_b = (tmr.ch4_counting_up ? state_reg.req_ctrl[TR_UP_B]
			: state_reg.req_ctrl[TR_DOWN_B])
			&& link_ok(state_reg.req_ctrl[TR_B_CH3_LINK],
			state_reg.req_ctrl[TR_B_CH4_LINK],
			tmr.ch3_skip_point, tmr.ch4_ovf_skip_point);
		n.req_a = tmr.delay_match_a && ok_a;
		n.req_b = tmr.delay_match_b && ok_b;
		n.cmp_req = tmr.ch3_compare_a_interrupt
			&& state_reg.cmp_req_en;

		// Source select; unknown codes start nothing
		unique case (state_reg.trg_sel)
			TRG_SRC_EXT:   src_pulse = tmr.ext_trigger;
			TRG_SRC_CMP_A: src_pulse = state_reg.cmp_req;
			TRG_SRC_REQ_A: src_pulse = state_reg.req_a;
			TRG_SRC_REQ_B: src_pulse = state_reg.req_b;
			default:       src_pulse = 1'b0;
		endcase
		trig = state_reg.hw_trg_en && src_pulse;
		accept = trig && (state_reg.cs == CONV_IDLE);
		done = (state_reg.cs == CONV_BUSY) && (state_reg.cnt == 10'd0);

		// Single mode, single-cycle scan: one pass then idle. Other
		// mode and scan codes are stored but run the same pass, and
		// the end-flag control bit steers nothing here.
		unique case (state_reg.cs)
			CONV_IDLE: begin
				if (accept) begin
					n.cs = CONV_BUSY;
					n.cnt = conv_cycles(state_reg.time_sel, state_reg.cksl);
				end
			end
			CONV_BUSY: begin
				if (done) begin
					n.cs = CONV_IDLE;
					n.result = adc_sample_data;
				end else begin
					n.cnt = state_reg.cnt - 10'd1;
				end
			end
		endcase

		// Register writes; hardware set beats software clear
		if (wr) begin
			unique case (apb.paddr)
				OFS_TRIGGER_SELECT: n.trg_sel = apb.pwdata[15:0];
				OFS_CONTROL_STATUS: begin
					if (apb.pwdata[CS_END_FLAG])
						n.end_flag = 1'b0;
					n.end_irq_en = apb.pwdata[CS_IRQ_EN];
					n.amp_on = apb.pwdata[CS_AMP_ON];
					n.hw_trg_en = apb.pwdata[CS_HW_TRG_EN];
					n.end_ctrl = apb.pwdata[CS_END_CTRL];
					n.time_sel = apb.pwdata[CS_TIME_SEL];
					n.cksl = apb.pwdata[CS_CLK_HI:CS_CLK_LO];
					n.adm = apb.pwdata[CS_MODE_HI:CS_MODE_LO];
					n.cont_scan = apb.pwdata[CS_CONT_SCAN];
					n.ch = apb.pwdata[2:0];
				end
				OFS_TIMER_REQ_CTRL:
					n.req_ctrl = apb.pwdata[15:0] & TR_WMASK;
				OFS_CMP_REQ_EN: n.cmp_req_en = apb.pwdata[CMP_REQ_EN_BIT];
				OFS_IRQ_STATUS: n.ists = state_reg.ists & ~apb.pwdata[1:0];
				OFS_IRQ_MASK: n.imask = apb.pwdata[1:0];
				default: ;
			endcase
		end
		if (done) begin
			n.end_flag = 1'b1;
			n.ists[IRQ_CONV_END] = 1'b1;
		end
		if (trig && !accept)
			n.ists[IRQ_OVERRUN] = 1'b1;

		// Read data and error latched in the setup cycle
		if (setup) begin
			n.err = !hit;
			n.rdata = 32'h0000_0000;
			unique case (apb.paddr)
				OFS_TRIGGER_SELECT: n.rdata[15:0] = state_reg.trg_sel;
				OFS_CONTROL_STATUS: n.rdata[15:0] = csr_rd;
				OFS_TIMER_REQ_CTRL: n.rdata[15:0] = state_reg.req_ctrl;
				OFS_CMP_REQ_EN:
					n.rdata[CMP_REQ_EN_BIT] = state_reg.cmp_req_en;
				OFS_IRQ_STATUS: n.rdata[1:0] = state_reg.ists;
				OFS_IRQ_MASK: n.rdata[1:0] = state_reg.imask;
				OFS_RESULT: n.rdata[9:0] = state_reg.result;
				default: ;
			endcase
		end
		state_next = n;
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.cs <= CONV_IDLE;
			state_reg.trg_sel <= RST_TRIGGER_SELECT;
			state_reg.req_ctrl <= RST_TIMER_REQ_CTRL;
			state_reg.end_flag <= RST_CONTROL_STATUS[CS_END_FLAG];
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Zero-wait slave: the answer is ready in every access phase
	assign pready = 1'b1;
	assign prdata = state_reg.rdata;
	assign pslverr = apb.psel && apb.penable && state_reg.err;
	assign delayed_start_request_a = state_reg.req_a;
	assign delayed_start_request_b = state_reg.req_b;
	assign compare_a_conv_request = state_reg.cmp_req;
	assign analog_channel = state_reg.ch;
	assign input_amp_on = state_reg.amp_on;
	assign conv_busy = (state_reg.cs == CONV_BUSY);
	assign conversion_end_interrupt = state_reg.end_flag
		&& state_reg.end_irq_en;
	assign irq = |(state_reg.ists & state_reg.imask);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_REQB_CH3: assert property (
		tmr.delay_match_b && tmr.ch3_skip_point && !tmr.ch4_ovf_skip_point
		&& !state_reg.req_ctrl[TR_B_CH3_LINK]
		&& state_reg.req_ctrl[TR_B_CH4_LINK]
		|=> !delayed_start_request_b)
		else $error("request B issued without ch3 linkage");
	AST_REQB_CH4: assert property (
		tmr.delay_match_b && tmr.ch4_ovf_skip_point && !tmr.ch3_skip_point
		&& !state_reg.req_ctrl[TR_B_CH4_LINK]
		&& state_reg.req_ctrl[TR_B_CH3_LINK]
		|=> !delayed_start_request_b)
		else $error("request B issued without ch4 linkage");
	AST_SEL_REQ_A: assert property (
		delayed_start_request_a && state_reg.trg_sel == TRG_SRC_REQ_A
		&& state_reg.hw_trg_en && !conv_busy |=> conv_busy)
		else $error("request A did not start conversion");
	AST_END_IRQ: assert property (
		conversion_end_interrupt
		== (state_reg.end_flag && state_reg.end_irq_en))
		else $error("end interrupt does not follow flag and enable");
	AST_FLAG_SET: assert property (
		conv_busy ##1 !conv_busy |-> state_reg.end_flag)
		else $error("end flag not set after conversion");
	AST_NO_TRG: assert property (
		!conv_busy && !state_reg.hw_trg_en |=> !conv_busy)
		else $error("conversion started with triggers disabled");
	AST_TIME_50: assert property (
		accept && !state_reg.time_sel && state_reg.cksl == CLK_DIV2
		|=> conv_busy [*8] ##92 done)
		else $error("50-state conversion at div 2 not 100 cycles");
	AST_CMP_GATE: assert property (
		!state_reg.cmp_req_en |=> !compare_a_conv_request)
		else $error("compare A request while disabled");
	AST_UP_A: assert property (
		tmr.delay_match_a && tmr.ch4_counting_up
		&& !state_reg.req_ctrl[TR_UP_A] |=> !delayed_start_request_a)
		else $error("request A while up-count disabled");
	AST_LINK_A: assert property (
		tmr.delay_match_a && tmr.ch3_skip_point && tmr.ch4_counting_up
		&& state_reg.req_ctrl[TR_UP_A]
		&& state_reg.req_ctrl[TR_A_CH3_LINK]
		|=> delayed_start_request_a)
		else $error("linked request A missing");
	AST_ONE_PASS: assert property (
		done |=> !conv_busy ##1 !conv_busy || $past(accept))
		else $error("converter did not return to idle");
	AST_AMP: assert property (
		wr && apb.paddr == OFS_CONTROL_STATUS
		|=> input_amp_on == $past(apb.pwdata[CS_AMP_ON]))
		else $error("amplifier enable not applied");

	CV_CONV: cover property (accept ##[1:600] done);
	CV_OVERRUN: cover property (trig && conv_busy);
	CV_REQ_A: cover property (delayed_start_request_a);
	CV_IRQ: cover property (irq && conversion_end_interrupt);
endmodule

// file: pkg/adc_trigger_pkg.sv
// Purpose: Constants and types for the converter trigger control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses on paddr[7:0]
package adc_trigger_pkg;
	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_TRIGGER_SELECT = 8'h00;
	localparam logic [7:0] OFS_CONTROL_STATUS = 8'h04;
	localparam logic [7:0] OFS_TIMER_REQ_CTRL = 8'h08;
	localparam logic [7:0] OFS_CMP_REQ_EN     = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS     = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK       = 8'h14;
	localparam logic [7:0] OFS_RESULT         = 8'h18;
	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] RST_TRIGGER_SELECT = 16'h0000;
	localparam logic [15:0] RST_CONTROL_STATUS = 16'h0000;
	localparam logic [15:0] RST_TIMER_REQ_CTRL = 16'h0000;
	// ------------------------------------------------------------------
	// Control and status field positions
	// ------------------------------------------------------------------
	localparam int CS_END_FLAG   = 15;
	localparam int CS_IRQ_EN     = 14;
	localparam int CS_AMP_ON     = 12;
	localparam int CS_HW_TRG_EN  = 11;
	localparam int CS_END_CTRL   = 9;
	localparam int CS_TIME_SEL   = 8;
	localparam int CS_CLK_HI     = 7;
	localparam int CS_CLK_LO     = 6;
	localparam int CS_MODE_HI    = 5;
	localparam int CS_MODE_LO    = 4;
	localparam int CS_CONT_SCAN  = 3;
	// Timer request control field positions
	localparam int TR_UP_A       = 7;
	localparam int TR_DOWN_A     = 6;
	localparam int TR_UP_B       = 5;
	localparam int TR_DOWN_B     = 4;
	localparam int TR_A_CH3_LINK = 3;
	localparam int TR_A_CH4_LINK = 2;
	localparam int TR_B_CH3_LINK = 1;
	localparam int TR_B_CH4_LINK = 0;
	localparam logic [15:0] TR_WMASK = 16'hc0ff;
	localparam int CMP_REQ_EN_BIT = 7;
	// Interrupt status bits
	localparam int IRQ_CONV_END = 0;
	localparam int IRQ_OVERRUN  = 1;
	// ------------------------------------------------------------------
	// Encodings and timing
	// ------------------------------------------------------------------
	localparam logic [15:0] TRG_SRC_EXT   = 16'h0001;
	localparam logic [15:0] TRG_SRC_CMP_A = 16'h0002;
	localparam logic [15:0] TRG_SRC_REQ_A = 16'h0003;
	localparam logic [15:0] TRG_SRC_REQ_B = 16'h0004;
	localparam logic [1:0]  MODE_SINGLE   = 2'b00;
	localparam logic [1:0]  CLK_DIV2      = 2'b10;
	localparam logic [6:0]  CONV_STATES_SHORT = 7'd50;
	localparam logic [6:0]  CONV_STATES_LONG  = 7'd64;

	typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic ch3_compare_a_interrupt;
		logic ch4_overflow_interrupt;
		logic ch3_skip_point;
		logic ch4_ovf_skip_point;
		logic ch4_counting_up;
		logic delay_match_a;
		logic delay_match_b;
		logic ext_trigger;
	} timer_evt_t;
endpackage

// file: tb/timer_event_model.sv
// Purpose: Behavioural timer that issues one-cycle event pulses
// Assumes: Bit order of the event vector follows timer_evt_t
// Notes:   Direction level is only driven during a pulse
`timescale 1ns/1ns
module timer_event_model
	import adc_trigger_pkg::*;
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	output adc_trigger_pkg::timer_evt_t tmr
);
	initial begin
		tmr = '0;
	end

	// ------------------------------------------------------------------
	// Event pulse, held quiet while reset is asserted
	// ------------------------------------------------------------------
	task automatic fire(input logic [7:0] bits);
		@(posedge pclk);
		if (presetn === 1'b1) begin
			tmr <= timer_evt_t'(bits);
		end
		@(posedge pclk);
		tmr <= '0;
	endtask
endmodule

// file: tb/test_adc_trigger_control.sv
// Purpose: Self-checking bench for adc_trigger_control
// Assumes: Zero-wait APB slave; timer events from timer_event_model
// Notes:   Pulse outputs are counted at every rising edge
`timescale 1ns/1ns
module test_adc_trigger_control;
	import adc_trigger_pkg::*;
	// Event bits in timer_evt_t order
	localparam logic [7:0] EV_CMP = 8'h80;
	localparam logic [7:0] EV_S3  = 8'h20;
	localparam logic [7:0] EV_S4  = 8'h10;
	localparam logic [7:0] EV_UP  = 8'h08;
	localparam logic [7:0] EV_MA  = 8'h04;
	localparam logic [7:0] EV_MB  = 8'h02;
	logic        pclk;
	logic        presetn;
	apb_req_t    apb;
	timer_evt_t  tmr;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        req_a;
	logic        req_b;
	logic        cmp_req;
	logic [2:0]  chan;
	logic        amp;
	logic        busy;
	logic        busy_d;
	logic        end_irq;
	logic        irq;
	int          n_errors;
	int          n_tests;
	int          cnt_a;
	int          cnt_b;
	int          cnt_cmp;
	int          starts;
	int          busy_cyc;

	adc_trigger_control DUT (.pclk(pclk), .presetn(presetn), .apb(apb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tmr(tmr),
		.adc_sample_data(10'h2a5), .delayed_start_request_a(req_a),
		.delayed_start_request_b(req_b), .compare_a_conv_request(cmp_req),
		.analog_channel(chan), .input_amp_on(amp), .conv_busy(busy),
		.conversion_end_interrupt(end_irq), .irq(irq));
	timer_event_model timer (.pclk(pclk), .presetn(presetn), .tmr(tmr));

	always #4 pclk = ~pclk;

	always @(posedge pclk) begin
		if (req_a === 1'b1) cnt_a++;
		if (req_b === 1'b1) cnt_b++;
		if (cmp_req === 1'b1) cnt_cmp++;
		if (busy === 1'b1) busy_cyc++;
		if (busy === 1'b1 && busy_d !== 1'b1) starts++;
		busy_d <= busy;
	end

	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task automatic close_out();
		if (n_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		apb.penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		r = prdata;
		e = pslverr;
		apb <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(a, 1'b1, d, r, e);
		// Let the write settle before any output is compared
		@(negedge pclk);
	endtask
	// Error flag folded into bit 31; registers leave it zero
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		xfer(a, 1'b0, 32'h0, r, e);
		chk({e, r[30:0]}, exp);
	endtask
	task automatic ev(input logic [7:0] x);
		timer.fire(x | EV_UP);
		repeat (3) @(posedge pclk);
	endtask
	task automatic idle();
		int n;
		n = 0;
		repeat (2) @(posedge pclk);
		while (busy === 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
	endtask

	// ------------------------------------------------------------------
	// Watchdog, far beyond the few hundred cycles the tests need
	// ------------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		close_out();
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		apb = '0;
		{n_errors, n_tests, cnt_a, cnt_b, cnt_cmp, starts, busy_cyc} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_TRIGGER_SELECT, {16'h0, RST_TRIGGER_SELECT});
		rd(OFS_CONTROL_STATUS, {16'h0, RST_CONTROL_STATUS});
		rd(OFS_TIMER_REQ_CTRL, {16'h0, RST_TIMER_REQ_CTRL});
		rd(8'h1c, 32'h80000000);
		wr(OFS_CONTROL_STATUS, 32'h0000ffff);
		rd(OFS_CONTROL_STATUS, 32'h00005bff);
		chk({29'h0, chan}, 32'h7);
		wr(OFS_CONTROL_STATUS, 32'h00005880);
		rd(OFS_CONTROL_STATUS, 32'h00005880);
		chk({29'h0, chan}, 32'h0);
		chk({31'h0, amp}, 32'h1);
		wr(OFS_TIMER_REQ_CTRL, 32'h0000ffff);
		rd(OFS_TIMER_REQ_CTRL, 32'h0000c0ff);
		wr(OFS_TIMER_REQ_CTRL, 32'h00000080);
		wr(OFS_TRIGGER_SELECT, 32'h00000003);
		wr(OFS_IRQ_MASK, 32'h00000001);
		ev(EV_MA);
		// Second request lands while busy and must be refused
		ev(EV_MA);
		idle();
		chk(32'(cnt_a), 32'd2);
		chk(32'(starts), 32'd1);
		chk(32'(busy_cyc), 32'd100);
		chk({30'h0, end_irq, irq}, 32'h3);
		rd(OFS_IRQ_STATUS, 32'h00000003);
		rd(OFS_CONTROL_STATUS, 32'h0000d880);
		rd(OFS_RESULT, 32'h000002a5);
		wr(OFS_CONTROL_STATUS, 32'h0000d880);
		wr(OFS_IRQ_STATUS, 32'h00000001);
		chk({30'h0, end_irq, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h00000003);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_STATUS, 32'h00000002);
		chk({31'h0, irq}, 32'h0);
		timer.fire(EV_MA);
		repeat (3) @(posedge pclk);
		chk(32'(cnt_a), 32'd2);
		wr(OFS_TIMER_REQ_CTRL, 32'h00000088);
		ev(EV_MA);
		chk(32'(cnt_a), 32'd2);
		ev(EV_MA | EV_S3);
		idle();
		chk(32'(cnt_a), 32'd3);
		chk(32'(starts), 32'd2);
		wr(OFS_TIMER_REQ_CTRL, 32'h00000021);
		ev(EV_MB | EV_S3);
		chk(32'(cnt_b), 32'd0);
		ev(EV_MB | EV_S4);
		chk(32'(cnt_b), 32'd1);
		wr(OFS_TIMER_REQ_CTRL, 32'h00000022);
		ev(EV_MB | EV_S4);
		chk(32'(cnt_b), 32'd1);
		ev(EV_MB | EV_S3);
		chk(32'(cnt_b), 32'd2);
		chk(32'(starts), 32'd2);
		wr(OFS_CONTROL_STATUS, 32'h00005080);
		wr(OFS_TIMER_REQ_CTRL, 32'h00000080);
		ev(EV_MA);
		chk(32'(cnt_a), 32'd4);
		chk(32'(starts), 32'd2);
		ev(EV_CMP);
		chk(32'(cnt_cmp), 32'd0);
		wr(OFS_CMP_REQ_EN, 32'h00000080);
		ev(EV_CMP);
		chk(32'(cnt_cmp), 32'd1);
		close_out();
	end
endmodule
